// ==== msd_pkg.sv ====
// Constants and types for the microsequencer byte datapath
package msd_pkg;
   localparam int PC_W      = 10;
   localparam int UI_W      = 16;
   localparam int CS_HALF   = 512;
   localparam int MEM_DEPTH = 256;
   localparam int TBL_DEPTH = 32;

   // Values after reset
   localparam logic [9:0]  PC_RST   = 10'h000;
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [15:0] UI_RST   = 16'h0000;

   // Host control register select that loads the maintenance microword
   localparam logic [2:0] SEL_MAINT = 3'h6;

   // Opcodes, microinstruction bits 15..13
   localparam logic [2:0] OPC_MOV_IMM  = 3'h0;
   localparam logic [2:0] OPC_MOV_IBUS = 3'h1;
   localparam logic [2:0] OPC_MOV_MEM  = 3'h2;
   localparam logic [2:0] OPC_MOV_BRG  = 3'h3;
   localparam logic [2:0] OPC_BR_IMM   = 3'h4;
   localparam logic [2:0] OPC_MOV_IBS2 = 3'h5;
   localparam logic [2:0] OPC_BR_MEM   = 3'h6;
   localparam logic [2:0] OPC_BR_BRG   = 3'h7;

   // Operand B multiplexer selects
   localparam logic [2:0] SRC_IMM  = 3'h0;
   localparam logic [2:0] SRC_LU   = 3'h1;
   localparam logic [2:0] SRC_MEM  = 3'h2;
   localparam logic [2:0] SRC_BRG  = 3'h3;
   localparam logic [2:0] SRC_EVEN = 3'h4;
   localparam logic [2:0] SRC_ODD  = 3'h5;
   localparam logic [2:0] SRC_BMC  = 3'h6;
   localparam logic [2:0] SRC_MISC = 3'h7;

   // Branch register modes {hi, lo}
   localparam logic [1:0] SHF_HOLD  = 2'h0;
   localparam logic [1:0] SHF_RIGHT = 2'h1;
   localparam logic [1:0] SHF_LOAD  = 2'h3;

   // Address register function, bits 12..11 of a move
   localparam logic [1:0] MARF_LOAD = 2'h1;
   localparam logic [1:0] MARF_INC  = 2'h2;

   // Destinations, bits 10..8 of a move
   localparam logic [2:0] DST_OUT   = 3'h0;
   localparam logic [2:0] DST_OUT2  = 3'h1;
   localparam logic [2:0] DST_SPAD  = 3'h2;
   localparam logic [2:0] DST_SPBRG = 3'h3;
   localparam logic [2:0] DST_BRG   = 3'h4;
   localparam logic [2:0] DST_MEM   = 3'h5;
   localparam logic [2:0] DST_SHIFT = 3'h6;

   // ALU function codes
   localparam logic [3:0] ALU_ADD   = 4'h0;
   localparam logic [3:0] ALU_ADDC  = 4'h1;
   localparam logic [3:0] ALU_SUBC  = 4'h2;
   localparam logic [3:0] ALU_INC   = 4'h3;
   localparam logic [3:0] ALU_APC   = 4'h4;
   localparam logic [3:0] ALU_2A    = 4'h5;
   localparam logic [3:0] ALU_2AC   = 4'h6;
   localparam logic [3:0] ALU_DEC   = 4'h7;
   localparam logic [3:0] ALU_SELA  = 4'h8;
   localparam logic [3:0] ALU_SELB  = 4'h9;
   localparam logic [3:0] ALU_AORNB = 4'ha;
   localparam logic [3:0] ALU_AND   = 4'hb;
   localparam logic [3:0] ALU_OR    = 4'hc;
   localparam logic [3:0] ALU_XOR   = 4'hd;
   localparam logic [3:0] ALU_SUB   = 4'he;
   localparam logic [3:0] ALU_SUB1  = 4'hf;

   typedef struct packed {
      logic addr_reg_load_n;
      logic addr_reg_inc_n;
      logic shift_mode_hi;
      logic shift_mode_lo;
      logic mem_wr_n;
      logic spad_wr;
      logic spad_addr_zero;
      logic out_bus_wr;
   } msd_dest_type;

   typedef struct packed {
      logic [4:0] func;
      logic       force_c;
      logic       enable_c;
      logic       store_flags;
   } msd_alu_ctl_type;
endpackage

// ==== msd_datapath.sv ====
// Microsequencer byte datapath: counter, control store, decode, memory, ALU
// ==========================================================================
// Summary of operation
// - Ten-bit counter addresses control store; increments or loads from buffered ALU.
// - Low condition selector output loads the branch address, otherwise increment.
// - Counter changes only at the late strobe's trailing edge.
// - Branch target is instruction bits 12..11 above the buffered ALU byte.
// - Bits 10..8 pick one of eight branch conditions.
// - Selector disabled for moves, which always increment; enabled for branches.
// - Right shift moves branch register down one bit, buffered ALU bit 0 into bit 7.
// - Mode 11 loads, 01 shifts right, 00 holds, 10 unused.
// - Branch register clocks only at trailing strobe edge during moves.
// - Working memory holds 256 bytes addressed by eight-bit address register.
// - Address register loads or increments at trailing edge of moves, active-low controls.
// - Destination ROM indexed by bits 12..8 drives register and write controls.
// - Memory write takes buffered ALU data at address register, active-low strobe.
// - Operand mux shows memory for opcodes 2 and 6; opcode 6 never writes.
// - 1024 words as two 512-word halves, counter top bit selects half.
// - Instruction fields address three decode ROMs; other bits control directly.
// - Host write to control select 6 loads the maintenance microword.
// - Inject bit gates maintenance word in, ORed, and disables control store.
// - Eight-to-one byte operand mux feeds ALU B, select from source ROM.
// - Selects 0..7: immediate, line unit, memory, branch reg, even, odd, bus ctl, misc.
// - Source ROM of 32 bytes indexed by opcode with bits 4 and 7.
// - Eight-bit ALU, five-bit function word, ten arithmetic and six logic operations.
// - ALU result captured into buffered register at strobe leading edge.
// - Zero flag when result all ones; carry stored under function ROM control.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps

module msd_datapath
(
   input  wire logic                  ref_clk,            // 10 MHz clock
   input  wire logic                  reset_n,            // Async reset
   input  wire logic                  late_phase_strobe,  // Microcycle strobe
   input  wire logic                  cs_load,            // Control store write
   input  wire logic [msd_pkg::PC_W-1:0] cs_load_addr,    // Control store index
   input  wire logic [msd_pkg::UI_W-1:0] cs_load_data,    // Control store word
   input  wire logic                  host_wr,            // Host register write
   input  wire logic [2:0]            host_sel,           // Host register select
   input  wire logic [15:0]           host_wdata,         // Host write data
   input  wire logic                  maint_inject_wr,    // Inject bit write
   input  wire logic                  maint_inject_val,   // Inject bit value
   input  wire logic [7:0]            cond_in,            // Branch conditions
   input  wire logic [7:0]            spad_data,          // ALU A operand
   input  wire logic [7:0]            line_unit_in_bus,   // Line unit byte
   input  wire logic [15:0]           bport_word,         // Multiport B word
   input  wire logic [7:0]            bus_master_ctl_reg, // Bus control byte
   input  wire logic [7:0]            misc_reg,           // Misc byte
   output logic [msd_pkg::PC_W-1:0]   upc,                // Microprogram counter
   output logic [msd_pkg::UI_W-1:0]   uinst_q,            // Registered microword
   output logic [7:0]                 mem_address_reg,    // Memory address
   output logic [7:0]                 branch_shift_reg,   // Branch register
   output logic [7:0]                 buffered_alu_out,   // Buffered ALU
   output logic                       carry_flag,         // Stored carry
   output logic                       zero_flag,          // Stored all-ones
   output logic                       maint_inject,       // Inject bit
   output logic                       spad_wr,            // Scratch write pulse
   output logic                       spad_addr_zero,     // Scratch address zero
   output logic                       out_bus_wr          // Secondary bus pulse
);
   import msd_pkg::*;
   // ======================================================================
   // Storage and state
   logic [UI_W-1:0] cs_lo [CS_HALF];
   logic [UI_W-1:0] cs_hi [CS_HALF];
   logic [7:0]      work_mem [MEM_DEPTH];
   logic [PC_W-1:0] upc_r;
   logic [UI_W-1:0] uinst_r;
   logic [UI_W-1:0] maint_word_r;
   logic            inject_r;
   logic            strobe_d_r;
   logic [7:0]      mar_r;
   logic [7:0]      brg_r;
   logic [7:0]      buffered_alu_out_r;
   logic            c_r;
   logic            z_r;
   logic            spad_wr_r;
   logic            spad_zero_r;
   logic            out_wr_r;
   logic [UI_W-1:0] cs_out;
   logic [UI_W-1:0] uinst;
   logic [2:0]      opc;
   logic            is_branch;
   logic            is_move;
   logic            lead;
   logic            trail;
   logic            cond_out;
   logic [PC_W-1:0] upc_nxt;
   msd_dest_type    dest;
   logic [7:0]      src_word;
   logic [2:0]      src_sel;
   logic [7:0]      mem_rd;
   logic [7:0]      opnd_b;
   msd_alu_ctl_type actl;
   logic            cin;
   logic [7:0]      y_in;
   logic [8:0]      alu_res;
   // ======================================================================
   // Decode ROM tables
   function automatic msd_dest_type dest_rom(input logic [4:0] a);
      msd_dest_type d;
      logic [2:0]   dst;
      logic [1:0]   marf;
      dst  = a[2:0];
      marf = a[4:3];
      d.addr_reg_load_n = (marf != MARF_LOAD);
      d.addr_reg_inc_n  = (marf != MARF_INC);
      case (dst)
         DST_BRG, DST_SPBRG : {d.shift_mode_hi, d.shift_mode_lo} = SHF_LOAD;
         DST_SHIFT          : {d.shift_mode_hi, d.shift_mode_lo} = SHF_RIGHT;
         default            : {d.shift_mode_hi, d.shift_mode_lo} = SHF_HOLD;
      endcase
      d.mem_wr_n       = (dst != DST_MEM);
      d.spad_wr        = (dst == DST_SPAD || dst == DST_SPBRG);
      d.spad_addr_zero = (dst == DST_OUT || dst == DST_OUT2);
      d.out_bus_wr     = (dst == DST_OUT2);
      return d;
   endfunction
   function automatic logic [7:0] src_rom(input logic [4:0] a);
      logic [2:0] s;
      case (a[4:2])
         OPC_MOV_IBUS, OPC_MOV_IBS2 : s = SRC_LU;
         OPC_MOV_MEM,  OPC_BR_MEM   : s = SRC_MEM;
         OPC_MOV_BRG,  OPC_BR_BRG   : s = SRC_BRG;
         default                    : s = SRC_IMM;
      endcase
      return {5'h00, s};
   endfunction
   function automatic msd_alu_ctl_type alu_rom(input logic [4:0] a);
      msd_alu_ctl_type f;
      logic            lg;
      lg = (a[3:0] >= ALU_SELA) && (a[3:0] <= ALU_XOR);
      f.func        = {lg, a[3:0]};
      f.force_c     = (a[3:0] == ALU_INC) || (a[3:0] == ALU_SUB);
      f.enable_c    = (a[3:0] == ALU_ADDC) || (a[3:0] == ALU_SUBC)
                   || (a[3:0] == ALU_APC) || (a[3:0] == ALU_2AC);
      f.store_flags = !lg;
      return f;
   endfunction
   // ======================================================================
   // Microinstruction fetch
   always_ff @(posedge ref_clk)
   begin
      if (cs_load)
      begin
         if (cs_load_addr[PC_W-1])
         begin
            cs_hi[cs_load_addr[PC_W-2:0]] <= cs_load_data;
         end
         else
         begin
            cs_lo[cs_load_addr[PC_W-2:0]] <= cs_load_data;
         end
      end
   end
   // Top counter bit picks the half
   assign cs_out = upc_r[PC_W-1] ? cs_hi[upc_r[PC_W-2:0]]
                                 : cs_lo[upc_r[PC_W-2:0]];
   // Inject gates store off and register on
   assign uinst = (inject_r ? '0 : cs_out) | (inject_r ? maint_word_r : '0);
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         maint_word_r <= UI_RST;
      end
      else if (host_wr && host_sel == SEL_MAINT)
      begin
         maint_word_r <= host_wdata;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         inject_r <= 1'b0;
      end
      else if (maint_inject_wr)
      begin
         inject_r <= maint_inject_val;
      end
   end
   // ======================================================================
   // Strobe edges and sequencing
   assign lead      = late_phase_strobe && !strobe_d_r;
   assign trail     = !late_phase_strobe && strobe_d_r;
   assign opc       = uinst[15:13];
   assign is_branch = (opc == OPC_BR_IMM) || (opc == OPC_BR_MEM) || (opc == OPC_BR_BRG);
   assign is_move   = !is_branch;
   // Disabled selector reads high
   assign cond_out  = is_branch ? cond_in[uinst[10:8]] : 1'b1;
   assign upc_nxt   = cond_out ? upc_r + 10'h001
                               : {uinst[12:11], buffered_alu_out_r};
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         strobe_d_r <= 1'b0;
         upc_r      <= PC_RST;
         uinst_r    <= UI_RST;
      end
      else
      begin
         strobe_d_r <= late_phase_strobe;
         uinst_r    <= uinst;
         if (trail)
         begin
            upc_r <= upc_nxt;
         end
      end
   end
   // ======================================================================
   // Second-level decode
   assign dest     = dest_rom(uinst[12:8]);
   assign src_word = src_rom({uinst[15:13], uinst[7], uinst[4]});
   assign src_sel  = src_word[2:0];
   assign actl     = alu_rom({uinst[14], uinst[7:4]});
   // ======================================================================
   // Working memory and address register
   assign mem_rd = work_mem[mar_r];
   always_ff @(posedge ref_clk)
   begin
      if (trail && is_move && !dest.mem_wr_n)
      begin
         work_mem[mar_r] <= buffered_alu_out_r;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mar_r <= BYTE_RST;
      end
      else if (trail && is_move)
      begin
         if (!dest.addr_reg_load_n)
         begin
            mar_r <= buffered_alu_out_r;
         end
         else if (!dest.addr_reg_inc_n)
         begin
            mar_r <= mar_r + 8'h01;
         end
      end
   end
   // ======================================================================
   // Branch shift register
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         brg_r <= BYTE_RST;
      end
      else if (trail && is_move)
      begin
         case ({dest.shift_mode_hi, dest.shift_mode_lo})
            SHF_LOAD  : brg_r <= buffered_alu_out_r;
            SHF_RIGHT : brg_r <= {buffered_alu_out_r[0], brg_r[7:1]};
            default   : brg_r <= brg_r;
         endcase
      end
   end
   // ======================================================================
   // Operand mux and ALU
   always_comb
   begin
      case (src_sel)
         SRC_IMM  : opnd_b = uinst[7:0];
         SRC_LU   : opnd_b = line_unit_in_bus;
         SRC_MEM  : opnd_b = mem_rd;
         SRC_BRG  : opnd_b = brg_r;
         SRC_EVEN : opnd_b = bport_word[7:0];
         SRC_ODD  : opnd_b = bport_word[15:8];
         SRC_BMC  : opnd_b = bus_master_ctl_reg;
         default  : opnd_b = misc_reg;
      endcase
   end
   assign cin = actl.force_c || (actl.enable_c && c_r);
   always_comb
   begin
      case (actl.func[3:0])
         ALU_ADD, ALU_ADDC            : y_in = opnd_b;
         ALU_SUBC, ALU_SUB, ALU_SUB1  : y_in = ~opnd_b;
         ALU_2A, ALU_2AC              : y_in = spad_data;
         ALU_DEC                      : y_in = 8'hff;
         default                      : y_in = 8'h00;
      endcase
      if (actl.func[4])
      begin
         case (actl.func[3:0])
            ALU_SELA  : alu_res = {1'b0, spad_data};
            ALU_SELB  : alu_res = {1'b0, opnd_b};
            ALU_AORNB : alu_res = {1'b0, spad_data | ~opnd_b};
            ALU_AND   : alu_res = {1'b0, spad_data & opnd_b};
            ALU_OR    : alu_res = {1'b0, spad_data | opnd_b};
            default   : alu_res = {1'b0, spad_data ^ opnd_b};
         endcase
      end
      else
      begin
         alu_res = {1'b0, spad_data} + {1'b0, y_in} + {8'h00, cin};
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         buffered_alu_out_r <= BYTE_RST;
         c_r    <= 1'b0;
         z_r    <= 1'b0;
      end
      else if (lead)
      begin
         buffered_alu_out_r <= alu_res[7:0];
         if (is_move && actl.store_flags)
         begin
            c_r <= alu_res[8];
            z_r <= &alu_res[7:0];
         end
      end
   end

   // ======================================================================
   // Destination strobes and scratch address-zero level to neighbouring blocks
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         spad_wr_r   <= 1'b0;
         spad_zero_r <= 1'b0;
         out_wr_r    <= 1'b0;
      end
      else
      begin
         spad_wr_r   <= trail && is_move && dest.spad_wr;
         spad_zero_r <= is_move && dest.spad_addr_zero;
         out_wr_r    <= trail && is_move && dest.out_bus_wr;
      end
   end

   assign upc              = upc_r;
   assign uinst_q          = uinst_r;
   assign mem_address_reg  = mar_r;
   assign branch_shift_reg = brg_r;
   assign buffered_alu_out = buffered_alu_out_r;
   assign carry_flag       = c_r;
   assign zero_flag        = z_r;
   assign maint_inject     = inject_r;
   assign spad_wr          = spad_wr_r;
   assign spad_addr_zero   = spad_zero_r;
   assign out_bus_wr       = out_wr_r;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_PC_STILL: assert property (!trail |=> $stable(upc_r))
      else $error("counter moved off trailing edge");
   AST_PC_INC: assert property (trail && cond_out |=> upc_r == $past(upc_r) + 10'h001)
      else $error("counter failed to increment");
   AST_PC_BRANCH: assert property (trail && !cond_out
      |=> upc_r == {$past(uinst[12:11]), $past(buffered_alu_out_r)})
      else $error("wrong branch target");
   AST_MOVE_NOBR: assert property (trail && is_move
      |=> upc_r == $past(upc_r) + 10'h001)
      else $error("move did not increment counter");
   AST_BRG_SHIFT: assert property (trail && is_move && !dest.shift_mode_hi
      && dest.shift_mode_lo |=> brg_r == {$past(buffered_alu_out_r[0]), $past(brg_r[7:1])})
      else $error("branch register rotate wrong");
   AST_BRG_IDLE: assert property (!(trail && is_move) |=> $stable(brg_r))
      else $error("branch register clocked off move edge");
   AST_MAR_INC: assert property (trail && is_move && dest.addr_reg_load_n
      && !dest.addr_reg_inc_n |=> mar_r == $past(mar_r) + 8'h01)
      else $error("address register failed to increment");
   AST_BUFFERED_ALU_OUT_CAP: assert property (lead |=> buffered_alu_out_r == $past(alu_res[7:0]))
      else $error("buffered ALU not captured");
   AST_MAINT_LD: assert property (host_wr && host_sel == SEL_MAINT
      |=> maint_word_r == $past(host_wdata))
      else $error("maintenance word not loaded");
   AST_INJECT: assert property (inject_r |-> uinst == maint_word_r)
      else $error("control store not disabled under inject");
   AST_MEM_SRC: assert property ((opc == OPC_MOV_MEM || opc == OPC_BR_MEM)
      |-> opnd_b == mem_rd)
      else $error("memory not selected as operand");
   AST_ZERO: assert property (lead && is_move && actl.store_flags
      |=> z_r == (buffered_alu_out_r == 8'hff))
      else $error("all-ones flag wrong");

   COV_BRANCH: cover property (trail && !cond_out);
   COV_SHIFT: cover property (trail && is_move && !dest.shift_mode_hi && dest.shift_mode_lo);
   COV_MEMWR: cover property (trail && is_move && !dest.mem_wr_n);
   COV_INJECT: cover property (inject_r && trail);
endmodule

// ==== msd_host_model.sv ====
// Host processor and line unit model on the far side of the datapath
`timescale 1ns/1ps

module msd_host_model
(
   input  wire logic        ref_clk,          // 10 MHz clock
   output logic             host_wr,          // Register write pulse
   output logic [2:0]       host_sel,         // Register select
   output logic [15:0]      host_wdata,       // Write data
   output logic [7:0]       line_unit_in_bus  // Line unit byte
);
   initial
   begin
      host_wr = 1'b0;
      host_sel = 3'h0;
      host_wdata = 16'h0000;
      line_unit_in_bus = 8'h5a;
   end

   // ==========================================================
   // One host register write, released data shows its inverse
   task automatic write_reg(input logic [2:0] sel, input logic [15:0] data);
      @(posedge ref_clk);
      host_wr <= 1'b1;
      host_sel <= sel;
      host_wdata <= data;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      host_sel <= ~sel;
      host_wdata <= ~data;
   endtask
endmodule

// ==== msd_datapath_tb.sv ====
// Self-checking testbench for the microsequencer byte datapath
`timescale 1ns/1ps

module msd_datapath_tb;
   import msd_pkg::*;
   logic        ref_clk, reset_n, late_phase_strobe, cs_load, host_wr;
   logic        maint_inject_wr, maint_inject_val, carry_flag, zero_flag;
   logic        maint_inject, spad_wr, spad_addr_zero, out_bus_wr;
   logic [9:0]  cs_load_addr, upc;
   logic [15:0] cs_load_data, host_wdata, uinst_q;
   logic [2:0]  host_sel;
   logic [7:0]  cond_in, line_unit_in_bus, mem_address_reg, spad_data;
   logic [7:0]  branch_shift_reg, buffered_alu_out;
   int          fail_count = 0;
   int          checks_done = 0;
   int          spad_pulses = 0;
   int          out_pulses = 0;

   // Microwords: opcode, MEM_ADDRESS_REG function or branch bits, destination or condition, low byte
   localparam logic [15:0] W0 = {OPC_MOV_IMM, MARF_LOAD, DST_BRG, 8'h9c};
   localparam logic [15:0] W1 = {OPC_MOV_IMM, 2'h0, DST_MEM, 8'h95};
   localparam logic [15:0] W2 = {OPC_MOV_IMM, 2'h0, DST_SHIFT, 8'h91};
   localparam logic [15:0] W3 = {OPC_BR_MEM, 2'h2, 3'h3, 8'h90};
   localparam logic [15:0] W4 = {OPC_BR_IMM, 2'h0, 3'h5, 8'h9f};
   localparam logic [15:0] WM = {OPC_MOV_IMM, 2'h0, DST_BRG, 8'h97};
   localparam logic [15:0] WX = {OPC_MOV_IMM, 2'h0, DST_BRG, 8'h93};
   // Decrement for flags, then selection of the line unit byte
   localparam logic [15:0] WD = {OPC_MOV_IMM, 2'h0, DST_OUT2, 8'h71};
   localparam logic [15:0] WC = {OPC_MOV_IMM, 2'h0, DST_SPAD, 8'h70};
   localparam logic [15:0] WL = {OPC_MOV_IBUS, 2'h0, 3'h7, 8'h90};

   msd_datapath u_dut
   (
      .ref_clk            (ref_clk),
      .reset_n            (reset_n),
      .late_phase_strobe  (late_phase_strobe),
      .cs_load            (cs_load),
      .cs_load_addr       (cs_load_addr),
      .cs_load_data       (cs_load_data),
      .host_wr            (host_wr),
      .host_sel           (host_sel),
      .host_wdata         (host_wdata),
      .maint_inject_wr    (maint_inject_wr),
      .maint_inject_val   (maint_inject_val),
      .cond_in            (cond_in),
      .spad_data          (spad_data),
      .line_unit_in_bus   (line_unit_in_bus),
      .bport_word         (16'h0000),
      .bus_master_ctl_reg (8'h00),
      .misc_reg           (8'h00),
      .upc                (upc),
      .uinst_q            (uinst_q),
      .mem_address_reg    (mem_address_reg),
      .branch_shift_reg   (branch_shift_reg),
      .buffered_alu_out   (buffered_alu_out),
      .carry_flag         (carry_flag),
      .zero_flag          (zero_flag),
      .maint_inject       (maint_inject),
      .spad_wr            (spad_wr),
      .spad_addr_zero     (spad_addr_zero),
      .out_bus_wr         (out_bus_wr)
   );

   msd_host_model u_host
   (
      .ref_clk          (ref_clk),
      .host_wr          (host_wr),
      .host_sel         (host_sel),
      .host_wdata       (host_wdata),
      .line_unit_in_bus (line_unit_in_bus)
   );

   always #50 ref_clk = ~ref_clk;

   // Count one-cycle destination pulses away from the launching edge
   always @(negedge ref_clk)
   begin
      if (spad_wr === 1'b1)
         spad_pulses++;
      if (out_bus_wr === 1'b1)
         out_pulses++;
   end

   // ==========================================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic load(input logic [9:0] addr, input logic [15:0] data);
      @(posedge ref_clk);
      cs_load <= 1'b1;
      cs_load_addr <= addr;
      cs_load_data <= data;
      @(posedge ref_clk);
      cs_load <= 1'b0;
   endtask

   task automatic inject(input logic val);
      @(posedge ref_clk);
      maint_inject_wr <= 1'b1;
      maint_inject_val <= val;
      @(posedge ref_clk);
      maint_inject_wr <= 1'b0;
   endtask

   // One microcycle, strobe high three clocks then low three
   task automatic ucycle();
      @(posedge ref_clk);
      late_phase_strobe <= 1'b1;
      repeat (3) @(posedge ref_clk);
      late_phase_strobe <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #10;
   endtask

   // ==========================================================
   initial
   begin
      repeat (6000) @(posedge ref_clk);
      fail_count++;
      report_and_stop();
   end

   initial
   begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      late_phase_strobe = 1'b0;
      cs_load = 1'b0;
      cs_load_addr = 10'h000;
      cs_load_data = 16'h0000;
      maint_inject_wr = 1'b0;
      maint_inject_val = 1'b0;
      cond_in = 8'h00;
      spad_data = 8'h00;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      #10;
      check(16'(upc), 16'(PC_RST));
      check(16'(maint_inject), 16'h0000);
      load(10'h000, W0);
      load(10'h001, W1);
      load(10'h002, W2);
      load(10'h003, W3);
      load(10'h295, W4);
      $display("test reset and store load done");
      ucycle();
      check(16'(upc), 16'h0001);
      check(16'(branch_shift_reg), 16'h009c);
      check(16'(mem_address_reg), 16'h009c);
      ucycle();
      check(16'(upc), 16'h0002);
      ucycle();
      check(16'(branch_shift_reg), 16'h00ce);
      check(16'(mem_address_reg), 16'h009c);
      $display("test moves done");
      @(posedge ref_clk);
      cond_in <= 8'hf7;
      ucycle();
      check(16'(buffered_alu_out), 16'h0095);
      check(16'(upc), 16'h0295);
      check(16'(branch_shift_reg), 16'h00ce);
      ucycle();
      check(16'(upc), 16'h0296);
      $display("test branches done");
      u_host.write_reg(SEL_MAINT, WM);
      u_host.write_reg(3'h5, WX);
      inject(1'b1);
      #10;
      check(16'(maint_inject), 16'h0001);
      ucycle();
      check(16'(branch_shift_reg), 16'h0097);
      check(16'(upc), 16'h0297);
      check(uinst_q, WM);
      $display("test maintenance word done");
      u_host.write_reg(SEL_MAINT, WD);
      ucycle();
      check(16'(buffered_alu_out), 16'h00ff);
      check(16'(zero_flag), 16'h0001);
      check(16'(carry_flag), 16'h0000);
      check(16'(spad_addr_zero), 16'h0001);
      check(16'(out_pulses), 16'h0001);
      u_host.write_reg(SEL_MAINT, WC);
      spad_data <= 8'h01;
      ucycle();
      check(16'(buffered_alu_out), 16'h0000);
      check(16'(carry_flag), 16'h0001);
      check(16'(zero_flag), 16'h0000);
      check(16'(spad_pulses), 16'h0001);
      check(16'(spad_addr_zero), 16'h0000);
      u_host.write_reg(SEL_MAINT, WL);
      ucycle();
      check(16'(buffered_alu_out), 16'h005a);
      check(16'(out_pulses), 16'h0001);
      $display("test flags and destinations done");
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      #10;
      check(16'(upc), 16'(PC_RST));
      check(16'(maint_inject), 16'h0000);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
